// ===== pkg/link_datapath_config_regs.vh
`ifndef LINK_DATAPATH_CONFIG_REGS_VH
`define LINK_DATAPATH_CONFIG_REGS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define LDC_ADDR_W 8
`define LDC_DATA_W 8
`define LDC_OFFSET 8'h28
`define LDC_RX_PORT_CTL_OFFSET 8'h34
`define LDC_RESET 8'h00
// read port idle values
`define LDC_RDATA_IDLE 8'h00
`define LDC_RVALID_IDLE 1'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define LDC_LOCK_BIT 7
`define LDC_RSVD_BIT 6
`define LDC_VIDEO_OFF_BIT 5
`define LDC_DUAL_LINK_BIT 4
`define LDC_ALT_AUDIO_BIT 3
`define LDC_AUDIO_OFF_BIT 2
`define LDC_SYNC_IN_STREAM_BIT 1
`define LDC_SURROUND_BIT 0
// mode fields loaded from the far end: bits 5..0
`define LDC_MODE_MASK 8'h3f

`endif

// ===== hdl/link_datapath_config_reg.v
`timescale 1ns/100ps
`include "link_datapath_config_regs.vh"

module link_datapath_config_reg (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// register access port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	// forward-channel configuration from the remote serializer
	input wire fc_cfg_valid,
	input wire [7:0] fc_cfg_data,
	// decoded controls to the datapath
	output reg video_disabled,
	output reg dual_link,
	output reg alt_audio_en,
	output reg audio_disabled,
	output reg sync_in_stream_en,
	output reg surround_en,
	output reg lock_local_config
);

// ----------------------------------------
// constants
// ----------------------------------------
// reset image and far-end mask as vectors so single bits can be picked
localparam [`LDC_DATA_W-1:0] RESET_VALUE = `LDC_RESET;
localparam [`LDC_DATA_W-1:0] MODE_MASK = `LDC_MODE_MASK;

// ----------------------------------------
// register storage
// ----------------------------------------
// stored register image and its next value
reg [`LDC_DATA_W-1:0] cfg;
wire [`LDC_DATA_W-1:0] next_cfg;
// strobes qualified by the address
wire wr_hit;
wire rd_hit;
// image after any local write, before the far-end load
wire [`LDC_DATA_W-1:0] wr_value;
// lock as it stands once the local write has landed
wire lock_after_wr;
// far-end load accepted this cycle
wire fc_load;
// read image presented to the data flop
wire [`LDC_DATA_W-1:0] rd_image;

// ----------------------------------------
// access decode
// ----------------------------------------
// true when the access port addresses this register
function hit;
	input [`LDC_ADDR_W-1:0] addr;
	begin
		hit = (addr == `LDC_OFFSET);
	end
endfunction

// other offsets, the receive-port control one too, leave this register alone
assign wr_hit = reg_wr && hit(reg_addr);
assign rd_hit = reg_rd && hit(reg_addr);

// ----------------------------------------
// next value
// ----------------------------------------
// a local write lands first, over the whole byte
assign wr_value = wr_hit ? reg_wdata : cfg;

// a write that sets the lock also refuses a load in the same cycle
assign lock_after_wr = wr_value[`LDC_LOCK_BIT];
assign fc_load = fc_cfg_valid && !lock_after_wr;

// mode bits follow the far end on a load; lock and reserved stay local
genvar i;
generate
	for (i = 0; i < `LDC_DATA_W; i = i + 1) begin : g_bit
		if (MODE_MASK[i]) begin : g_mode
			assign next_cfg[i] = fc_load ? fc_cfg_data[i] : wr_value[i];
		end else begin : g_local
			assign next_cfg[i] = wr_value[i];
		end
	end
endgenerate

// ----------------------------------------
// register update
// ----------------------------------------
// holds the reset image until the first local write or far-end load
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		cfg <= RESET_VALUE;
	end else begin
		cfg <= next_cfg;
	end
end

// ----------------------------------------
// field extraction
// ----------------------------------------
// next state of each field, as the output flops take it
wire next_video_off;
wire next_dual_link;
wire next_alt_audio;
wire next_audio_off;
wire next_sync_in_stream;
wire next_surround;
wire next_lock;

// pick each field out of the next image
assign next_video_off = next_cfg[`LDC_VIDEO_OFF_BIT];
assign next_dual_link = next_cfg[`LDC_DUAL_LINK_BIT];
assign next_alt_audio = next_cfg[`LDC_ALT_AUDIO_BIT];
assign next_audio_off = next_cfg[`LDC_AUDIO_OFF_BIT];
assign next_sync_in_stream = next_cfg[`LDC_SYNC_IN_STREAM_BIT];
assign next_surround = next_cfg[`LDC_SURROUND_BIT];
assign next_lock = next_cfg[`LDC_LOCK_BIT];

// ----------------------------------------
// read path
// ----------------------------------------
// only a read of this offset returns the image; anything else reads idle
assign rd_image = rd_hit ? cfg : `LDC_RDATA_IDLE;

// read strobe echoed one cycle later, for any address
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		reg_rvalid <= `LDC_RVALID_IDLE;
	end else begin
		reg_rvalid <= reg_rd;
	end
end

// read data registered one cycle after the strobe
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		reg_rdata <= `LDC_RDATA_IDLE;
	end else begin
		reg_rdata <= rd_image;
	end
end

// ----------------------------------------
// decoded control outputs
// ----------------------------------------
// video-off status
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		video_disabled <= RESET_VALUE[`LDC_VIDEO_OFF_BIT];
	end else begin
		video_disabled <= next_video_off;
	end
end

// dual or single link indication
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		dual_link <= RESET_VALUE[`LDC_DUAL_LINK_BIT];
	end else begin
		dual_link <= next_dual_link;
	end
end

// alternate audio routing
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		alt_audio_en <= RESET_VALUE[`LDC_ALT_AUDIO_BIT];
	end else begin
		alt_audio_en <= next_alt_audio;
	end
end

// audio suppress
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		audio_disabled <= RESET_VALUE[`LDC_AUDIO_OFF_BIT];
	end else begin
		audio_disabled <= next_audio_off;
	end
end

// sync carried in stream
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		sync_in_stream_en <= RESET_VALUE[`LDC_SYNC_IN_STREAM_BIT];
	end else begin
		sync_in_stream_en <= next_sync_in_stream;
	end
end

// surround audio enable
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		surround_en <= RESET_VALUE[`LDC_SURROUND_BIT];
	end else begin
		surround_en <= next_surround;
	end
end

// local lock
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		lock_local_config <= RESET_VALUE[`LDC_LOCK_BIT];
	end else begin
		lock_local_config <= next_lock;
	end
end

endmodule // link_datapath_config_reg

// ===== tb/link_datapath_config_reg_props.sv
`timescale 1ns/100ps
module link_datapath_config_reg_props (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// register access port
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	// forward channel
	input wire fc_cfg_valid,
	input wire [7:0] fc_cfg_data,
	// decoded controls
	input wire video_disabled,
	input wire dual_link,
	input wire alt_audio_en,
	input wire audio_disabled,
	input wire sync_in_stream_en,
	input wire surround_en,
	input wire lock_local_config
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// write to the register, forward load while locked, forward load while open
	wire w = reg_wr && reg_addr == 8'h28 && !fc_cfg_valid;
	wire k = fc_cfg_valid && !reg_wr && lock_local_config;
	wire u = fc_cfg_valid && !reg_wr && !lock_local_config;
	a_hold_dual: assert property (k |=> $stable(dual_link)) else $error("dual");
	a_hold_video: assert property (k |=> $stable(video_disabled)) else $error("vid");
	a_ld_video: assert property (u |=> video_disabled == $past(fc_cfg_data[5])) else $error("v");
	a_ld_dual: assert property (u |=> dual_link == $past(fc_cfg_data[4])) else $error("d");
	a_wr_alt: assert property (w |=> alt_audio_en == $past(reg_wdata[3])) else $error("alt");
	a_wr_aud: assert property (w |=> audio_disabled == $past(reg_wdata[2])) else $error("aud");
	a_wr_sync: assert property (w |=> sync_in_stream_en == $past(reg_wdata[1])) else $error("s");
	a_wr_sur: assert property (w |=> surround_en == $past(reg_wdata[0])) else $error("sur");
	a_wr_lock: assert property (w |=> lock_local_config == $past(reg_wdata[7])) else $error("lock");
endmodule // link_datapath_config_reg_props

// ===== tb/fc_source.sv
`timescale 1ns/100ps
module fc_source (
	// clock
	input wire clk_sys,
	// request from the bench
	input wire send,
	input wire [7:0] cfg,
	// forward-channel configuration to the receiver
	output reg fc_cfg_valid = 1'h0,
	output reg [7:0] fc_cfg_data = 8'h00
);
	// one config byte per request, idle bytes scrambled
	always @(posedge clk_sys) begin
		fc_cfg_valid <= send;
		fc_cfg_data <= send ? cfg : ~fc_cfg_data;
	end
endmodule // fc_source

// ===== tb/link_datapath_config_reg_test.sv
`timescale 1ns/100ps
module link_datapath_config_reg_test;
	logic clk_sys = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, send = 1'h0;
	logic reg_rvalid, fc_cfg_valid;
	logic video_disabled, dual_link, alt_audio_en, audio_disabled, sync_in_stream_en;
	logic surround_en, lock_local_config;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cfg = 8'h00, reg_rdata, fc_cfg_data;
	int miscompares = 0, n_checks = 0;
	always #50 clk_sys = ~clk_sys;
	link_datapath_config_reg u_link_datapath_config_reg (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.fc_cfg_valid(fc_cfg_valid),
		.fc_cfg_data(fc_cfg_data),
		.video_disabled(video_disabled),
		.dual_link(dual_link),
		.alt_audio_en(alt_audio_en),
		.audio_disabled(audio_disabled),
		.sync_in_stream_en(sync_in_stream_en),
		.surround_en(surround_en),
		.lock_local_config(lock_local_config)
	);
	fc_source u_fc_source (
		.clk_sys(clk_sys),
		.send(send),
		.cfg(cfg),
		.fc_cfg_valid(fc_cfg_valid),
		.fc_cfg_data(fc_cfg_data)
	);
	// byte compare of the read data
	task chk(string n, logic [7:0] e);
		n_checks++;
		if (reg_rdata !== e) begin
			miscompares++;
			$display("BAD %s %h %h", n, e, reg_rdata);
		end
	endtask
	// single-bit compare of a flag or control output
	task chk1(string n, logic e, logic s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s %h %h", n, e, s);
		end
	endtask
	task acc(logic w, logic [7:0] a, d);
		@(posedge clk_sys) #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge clk_sys) #1 {reg_wr, reg_rd} = 2'h0;
	endtask
	task fc(logic [7:0] d);
		@(posedge clk_sys) #1 {send, cfg} = {1'h1, d};
		@(posedge clk_sys) #1 send = 1'h0;
	endtask
	// forward byte and local write taken at the same edge
	task both(logic [7:0] f, d);
		@(posedge clk_sys) #1 {send, cfg} = {1'h1, f};
		@(posedge clk_sys) #1 {send, reg_wr, reg_addr, reg_wdata} = {1'h0, 1'h1, 8'h28, d};
		@(posedge clk_sys) #1 reg_wr = 1'h0;
	endtask
	// reset image, load, lock against a load, stray address, unlock and load
	task t_lock;
		acc(1'h0, 8'h28, 8'h00);
		chk("reset", 8'h00);
		fc(8'hff);
		acc(1'h0, 8'h28, 8'h00);
		chk("load", 8'h3f);
		chk1("rvalid", 1'h1, reg_rvalid);
		acc(1'h1, 8'h28, 8'h9d);
		chk1("lock out", 1'h1, lock_local_config);
		fc(8'h2a);
		acc(1'h1, 8'h34, 8'hff);
		chk1("wr rvalid", 1'h0, reg_rvalid);
		chk1("dual held", 1'h1, dual_link);
		chk1("video held", 1'h0, video_disabled);
		acc(1'h0, 8'h28, 8'h00);
		chk("lock", 8'h9d);
		acc(1'h1, 8'h28, 8'h00);
		fc(8'h2a);
		acc(1'h0, 8'h34, 8'h00);
		chk("stray", 8'h00);
		chk1("stray rvalid", 1'h1, reg_rvalid);
		chk1("video load", 1'h1, video_disabled);
		acc(1'h0, 8'h28, 8'h00);
		chk("open", 8'h2a);
	endtask
	// same-edge write and load: a locking write refuses, an open one loses mode bits
	task t_collide;
		both(8'h3f, 8'h80);
		acc(1'h0, 8'h28, 8'h00);
		chk("wr lock wins", 8'h80);
		both(8'h2a, 8'h15);
		acc(1'h0, 8'h28, 8'h00);
		chk("fc wins", 8'h2a);
	endtask
	// mid-run reset returns image and outputs to the reset state
	task t_reset;
		acc(1'h1, 8'h28, 8'hff);
		chk1("pre rst lock", 1'h1, lock_local_config);
		@(posedge clk_sys) #1 nrst = 1'h0;
		@(posedge clk_sys) #1 chk1("rst lock", 1'h0, lock_local_config);
		chk1("rst video", 1'h0, video_disabled);
		chk1("rst rvalid", 1'h0, reg_rvalid);
		nrst = 1'h1;
		acc(1'h0, 8'h28, 8'h00);
		chk("rst read", 8'h00);
		fc(8'h15);
		acc(1'h0, 8'h28, 8'h00);
		chk("rst load", 8'h15);
	endtask
	// verdict and end of run
	task end_sim;
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		#1 nrst = 1'h1;
		t_lock;
		t_collide;
		t_reset;
		end_sim;
	end
	// watchdog, about three and a half times the expected run
	initial begin
		#20000 miscompares++;
		end_sim;
	end
endmodule // link_datapath_config_reg_test
bind link_datapath_config_reg link_datapath_config_reg_props u_p (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.reg_wr(reg_wr),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.fc_cfg_valid(fc_cfg_valid),
	.fc_cfg_data(fc_cfg_data),
	.video_disabled(video_disabled),
	.dual_link(dual_link),
	.alt_audio_en(alt_audio_en),
	.audio_disabled(audio_disabled),
	.sync_in_stream_en(sync_in_stream_en),
	.surround_en(surround_en),
	.lock_local_config(lock_local_config)
);
